// ### core/occ_clkdiv.sv
// module: channel four output divider, counts rising edges of the sampled source
`default_nettype none
module occ_clkdiv
	import occ_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// divider hookup
	occ_div_if.core dv
);
	logic src_d_r;
	logic [7:0] cnt_r;
	logic pass_r;
	logic out_r;
	logic rise;
	logic wrap;

	assign rise = dv.src & ~src_d_r;
	assign wrap = (cnt_r >= dv.ratio);
	assign dv.out = out_r;

	always_ff @(posedge clk)
	begin
		if (rst)
			src_d_r <= 1'b0;
		else
			src_d_r <= dv.src;
	end

	// one source period in ratio+1 is let through
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= 8'h00;
			pass_r <= 1'b0;
		end
		else if (rise)
		begin
			cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
			pass_r <= wrap;
		end
	end

	// references go straight through, undivided
	always_ff @(posedge clk)
	begin
		if (rst)
			out_r <= 1'b0;
		else if (dv.bypass)
			out_r <= dv.src;
		else
			out_r <= dv.src & (rise ? wrap : pass_r);
	end

	property p_div_one;
		@(posedge clk) disable iff (rst)
		(!dv.bypass && dv.ratio == 8'h00 && cnt_r == 8'h00) |=> (out_r == $past(dv.src));
	endproperty
	a_div_one: assert property (p_div_one) else $error("divide by one does not follow source");

	property p_div_block;
		@(posedge clk) disable iff (rst)
		(!dv.bypass && rise && cnt_r < dv.ratio) |=> !out_r;
	endproperty
	a_div_block: assert property (p_div_block) else $error("divider passed a non-terminal edge");

	property p_bypass;
		@(posedge clk) disable iff (rst)
		dv.bypass |=> (out_r == $past(dv.src));
	endproperty
	a_bypass: assert property (p_bypass) else $error("reference source was divided");
endmodule // occ_clkdiv
`default_nettype wire

// ### core/occ_top.sv
// module: channel four divider and channel five control register bank on apb
// ************************************************************
// Summary of operation
// - channel four divider: 8-bit value N divides by N+1, 0 by 1, 255 by 256
// - divider acts only on synthesizer sources; references pass undivided
// - channel five source: 0 synth one, 1 synth two, 2 primary, 3 secondary reference
// - channel five driver: 0 off, 1 ac differential, 2 hcsl, 3 lvcmos
// - mode a: tail current 4/6/8/16 mA (8 unless hcsl), cmos positive pin state
// - mode b: hcsl load tristate/50/100/200 ohm, cmos negative pin state
// - reset: driver ac differential, mode a 2, mode b 0, source 0
// ************************************************************
//
// The implementer's own choice: the APB register port.
`default_nettype none
module occ_top
	import occ_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// clock sources, sampled as levels
	input wire logic SYNTH_ONE_CLK,
	input wire logic SYNTH_TWO_CLK,
	input wire logic PRI_REF_CLK,
	input wire logic SEC_REF_CLK,
	// channel four
	output logic CH4_OUT,
	// channel five pins
	output logic CH5_P_OUT,
	output logic CH5_P_OE_N,
	output logic CH5_N_OUT,
	output logic CH5_N_OE_N,
	// channel five analog settings
	output logic [4:0] CH5_TAIL_MA,
	output logic [7:0] CH5_LOAD_OHM
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] ch4_div_r;
	logic [1:0] ch4_src_r;
	logic [1:0] ch5_source_select_r;
	logic [1:0] ch5_drv_sel_r;
	logic [1:0] ch5_drive_cfg_a_r;
	logic [1:0] ch5_drive_cfg_b_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic src4_r;
	logic ch5_clk_r;
	logic ch4_out_r;
	logic p_out_r, p_oe_n_r, n_out_r, n_oe_n_r;
	logic [4:0] tail_r;
	logic [7:0] load_r;

	logic setup;
	logic wr_take;
	logic [7:0] idx;
	logic idx_ok;
	logic [31:0] rd_nxt;
	logic [7:0] ch5_ctl;
	logic [7:0] status;
	logic p_out_nxt, p_oe_n_nxt, n_out_nxt, n_oe_n_nxt;
	logic [4:0] tail_nxt;
	logic [7:0] load_nxt;

	occ_div_if div_if ();

	occ_clkdiv u_div (
		.clk (CLK),
		.rst (RST),
		.dv (div_if.core)
	);

	// ************************************************************
	// apb slave: answers in the first access cycle, no wait states
	// ************************************************************
	assign setup = PSEL & ~PENABLE;
	assign wr_take = PSEL & PENABLE & PWRITE & pready_r;
	assign idx = PADDR[9:2];
	assign idx_ok = (PADDR[1:0] == 2'b00) && (PADDR[ADDR_W-1:10] == '0) &&
		(idx == OCC_IDX_CH4_DIV || idx == OCC_IDX_CH5_CTL ||
		idx == OCC_IDX_CH4_SRC || idx == OCC_IDX_STATUS);
	assign ch5_ctl = {ch5_source_select_r, ch5_drv_sel_r, ch5_drive_cfg_a_r, ch5_drive_cfg_b_r};
	assign status = {4'h0, div_if.bypass, ch5_clk_r, p_oe_n_r, n_oe_n_r};

	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		if (idx == OCC_IDX_CH4_DIV)
			rd_nxt = {24'h00_0000, ch4_div_r};
		else if (idx == OCC_IDX_CH5_CTL)
			rd_nxt = {24'h00_0000, ch5_ctl};
		else if (idx == OCC_IDX_CH4_SRC)
			rd_nxt = {30'h0000_0000, ch4_src_r};
		else if (idx == OCC_IDX_STATUS)
			rd_nxt = {24'h00_0000, status};
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= setup;
			pslverr_r <= setup & ~idx_ok;
			prdata_r <= (setup && !PWRITE && idx_ok) ? rd_nxt : 32'h0000_0000;
		end
	end

	// ************************************************************
	// register writes
	// ************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
			ch4_div_r <= OCC_CH4_DIV_RST;
		else if (wr_take && idx_ok && idx == OCC_IDX_CH4_DIV)
			ch4_div_r <= PWDATA[7:0];
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			ch4_src_r <= OCC_SRC_RST;
		else if (wr_take && idx_ok && idx == OCC_IDX_CH4_SRC)
			ch4_src_r <= PWDATA[1:0];
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ch5_source_select_r <= OCC_SRC_RST;
			ch5_drv_sel_r <= OCC_SEL_RST;
			ch5_drive_cfg_a_r <= OCC_MODE_A_RST;
			ch5_drive_cfg_b_r <= OCC_MODE_B_RST;
		end
		else if (wr_take && idx_ok && idx == OCC_IDX_CH5_CTL)
		begin
			ch5_source_select_r <= PWDATA[OCC_SRC_LSB +: 2];
			ch5_drv_sel_r <= PWDATA[OCC_SEL_LSB +: 2];
			ch5_drive_cfg_a_r <= PWDATA[OCC_MODE_A_LSB +: 2];
			ch5_drive_cfg_b_r <= PWDATA[OCC_MODE_B_LSB +: 2];
		end
	end

	// ************************************************************
	// source muxes
	// ************************************************************
	function automatic logic pick(input logic [1:0] s, input logic a, input logic b,
		input logic c, input logic d);
		unique case (occ_src_t'(s))
			OCC_SRC_SYNTH_ONE: pick = a;
			OCC_SRC_SYNTH_TWO: pick = b;
			OCC_SRC_PRI_REF: pick = c;
			OCC_SRC_SEC_REF: pick = d;
		endcase
	endfunction

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			src4_r <= 1'b0;
			ch5_clk_r <= 1'b0;
			ch4_out_r <= 1'b0;
		end
		else
		begin
			src4_r <= pick(ch4_src_r, SYNTH_ONE_CLK, SYNTH_TWO_CLK, PRI_REF_CLK, SEC_REF_CLK);
			ch5_clk_r <= pick(ch5_source_select_r, SYNTH_ONE_CLK, SYNTH_TWO_CLK,
				PRI_REF_CLK, SEC_REF_CLK);
			ch4_out_r <= div_if.out;
		end
	end

	assign div_if.src = src4_r;
	assign div_if.ratio = ch4_div_r;
	assign div_if.bypass = ch4_src_r[1];

	// ************************************************************
	// channel five driver decode
	// ************************************************************
	function automatic logic [1:0] cmos_pin(input logic [1:0] cfg, input logic ck);
		unique case (cfg)
			OCC_PIN_OFF_Z: cmos_pin = 2'b01;
			OCC_PIN_OFF_LOW: cmos_pin = 2'b00;
			OCC_PIN_INV: cmos_pin = {~ck, 1'b0};
			OCC_PIN_TRUE: cmos_pin = {ck, 1'b0};
		endcase
	endfunction

	always_comb
	begin
		p_out_nxt = 1'b0;
		p_oe_n_nxt = 1'b1;
		n_out_nxt = 1'b0;
		n_oe_n_nxt = 1'b1;
		tail_nxt = 5'h00;
		load_nxt = OCC_LOAD_Z;
		unique case (occ_drv_t'(ch5_drv_sel_r))
			OCC_DRV_OFF:
			begin
				p_oe_n_nxt = 1'b1;
				n_oe_n_nxt = 1'b1;
			end
			OCC_DRV_ACDIFF, OCC_DRV_HCSL:
			begin
				p_out_nxt = ch5_clk_r;
				n_out_nxt = ~ch5_clk_r;
				p_oe_n_nxt = 1'b0;
				n_oe_n_nxt = 1'b0;
				unique case (ch5_drive_cfg_a_r)
					2'h0: tail_nxt = OCC_TAIL_4MA;
					2'h1: tail_nxt = OCC_TAIL_6MA;
					2'h2: tail_nxt = OCC_TAIL_8MA;
					2'h3: tail_nxt = (ch5_drv_sel_r == OCC_DRV_HCSL) ? OCC_TAIL_16MA : OCC_TAIL_8MA;
				endcase
				if (ch5_drv_sel_r == OCC_DRV_HCSL)
				begin
					unique case (ch5_drive_cfg_b_r)
						2'h0: load_nxt = OCC_LOAD_Z;
						2'h1: load_nxt = OCC_LOAD_50;
						2'h2: load_nxt = OCC_LOAD_100;
						2'h3: load_nxt = OCC_LOAD_200;
					endcase
				end
			end
			OCC_DRV_CMOS:
			begin
				{p_out_nxt, p_oe_n_nxt} = cmos_pin(ch5_drive_cfg_a_r, ch5_clk_r);
				{n_out_nxt, n_oe_n_nxt} = cmos_pin(ch5_drive_cfg_b_r, ch5_clk_r);
			end
		endcase
	end

	// pins are tristated in reset, when off, and for cmos pins at OCC_PIN_OFF_Z; the ac differential reset setting drives them from the next cycle
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			p_out_r <= 1'b0;
			p_oe_n_r <= 1'b1;
			n_out_r <= 1'b0;
			n_oe_n_r <= 1'b1;
			tail_r <= 5'h00;
			load_r <= OCC_LOAD_Z;
		end
		else
		begin
			p_out_r <= p_out_nxt;
			p_oe_n_r <= p_oe_n_nxt;
			n_out_r <= n_out_nxt;
			n_oe_n_r <= n_oe_n_nxt;
			tail_r <= tail_nxt;
			load_r <= load_nxt;
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign CH4_OUT = ch4_out_r;
	assign CH5_P_OUT = p_out_r;
	assign CH5_P_OE_N = p_oe_n_r;
	assign CH5_N_OUT = n_out_r;
	assign CH5_N_OE_N = n_oe_n_r;
	assign CH5_TAIL_MA = tail_r;
	assign CH5_LOAD_OHM = load_r;

	// ************************************************************
	// checks
	// ************************************************************
	property p_ch5_route;
		@(posedge CLK) disable iff (RST)
		(ch5_source_select_r == OCC_SRC_PRI_REF && $stable(ch5_source_select_r)) |=>
			(ch5_clk_r == $past(PRI_REF_CLK));
	endproperty
	a_ch5_route: assert property (p_ch5_route) else $error("channel five not fed by primary ref");

	property p_ch5_route_two;
		@(posedge CLK) disable iff (RST)
		(ch5_source_select_r == OCC_SRC_SYNTH_TWO) |=> (ch5_clk_r == $past(SYNTH_TWO_CLK));
	endproperty
	a_ch5_route_two: assert property (p_ch5_route_two) else $error("channel five not fed by synth two");

	property p_drv_off;
		@(posedge CLK) disable iff (RST)
		(ch5_drv_sel_r == OCC_DRV_OFF) [*2] |-> (CH5_P_OE_N && CH5_N_OE_N && CH5_TAIL_MA == 5'h00);
	endproperty
	a_drv_off: assert property (p_drv_off) else $error("disabled channel five still drives");

	property p_diff_pins;
		@(posedge CLK) disable iff (RST)
		(ch5_drv_sel_r == OCC_DRV_ACDIFF) |=> (!CH5_P_OE_N && CH5_N_OUT == !CH5_P_OUT &&
			CH5_P_OUT == $past(ch5_clk_r));
	endproperty
	a_diff_pins: assert property (p_diff_pins) else $error("differential pins not complementary");

	property p_tail;
		@(posedge CLK) disable iff (RST)
		(ch5_drive_cfg_a_r == 2'h3 && ch5_drv_sel_r inside {OCC_DRV_ACDIFF, OCC_DRV_HCSL}) |=>
			(CH5_TAIL_MA == (($past(ch5_drv_sel_r) == OCC_DRV_HCSL) ? OCC_TAIL_16MA : OCC_TAIL_8MA));
	endproperty
	a_tail: assert property (p_tail) else $error("wrong tail current for top code");

	property p_cmos_p_inv;
		@(posedge CLK) disable iff (RST)
		(ch5_drv_sel_r == OCC_DRV_CMOS && ch5_drive_cfg_a_r == OCC_PIN_INV) |=>
			(!CH5_P_OE_N && CH5_P_OUT == !$past(ch5_clk_r));
	endproperty
	a_cmos_p_inv: assert property (p_cmos_p_inv) else $error("cmos positive pin not inverted");

	property p_load;
		@(posedge CLK) disable iff (RST)
		(ch5_drv_sel_r == OCC_DRV_HCSL && ch5_drive_cfg_b_r == 2'h2) |=> (CH5_LOAD_OHM == OCC_LOAD_100);
	endproperty
	a_load: assert property (p_load) else $error("hcsl load not 100 ohm");

	property p_cmos_n_z;
		@(posedge CLK) disable iff (RST)
		(ch5_drv_sel_r == OCC_DRV_CMOS && ch5_drive_cfg_b_r == OCC_PIN_OFF_Z) |=> CH5_N_OE_N;
	endproperty
	a_cmos_n_z: assert property (p_cmos_n_z) else $error("cmos negative pin not tristated");

	property p_reset_vals;
		@(posedge CLK) disable iff (RST)
		$fell(RST) |-> (ch5_ctl == {OCC_SRC_RST, OCC_SEL_RST, OCC_MODE_A_RST, OCC_MODE_B_RST} &&
			ch4_div_r == OCC_CH4_DIV_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("control register reset value wrong");
endmodule // occ_top
`default_nettype wire

// ### pkg/occ_div_if.sv
// interface: channel four divider hookup between the register bank and the divider
`default_nettype none
interface occ_div_if;
	logic src;
	logic bypass;
	logic [7:0] ratio;
	logic out;
	modport core (input src, input bypass, input ratio, output out);
	modport ctl (output src, output bypass, output ratio, input out);
endinterface
`default_nettype wire

// ### pkg/occ_pkg.sv
// package: register map, field layout, reset values and encodings of the output channel block
`default_nettype none
package occ_pkg;
	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] OCC_IDX_CH4_DIV = 8'h26;
	localparam logic [7:0] OCC_IDX_CH5_CTL = 8'h27;
	localparam logic [7:0] OCC_IDX_CH4_SRC = 8'h30;
	localparam logic [7:0] OCC_IDX_STATUS = 8'h31;

	// ************************************************************
	// field positions in channel_five_control
	// ************************************************************
	localparam int OCC_SRC_LSB = 6;
	localparam int OCC_SEL_LSB = 4;
	localparam int OCC_MODE_A_LSB = 2;
	localparam int OCC_MODE_B_LSB = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] OCC_CH4_DIV_RST = 8'h02;
	localparam logic [1:0] OCC_SRC_RST = 2'h0;
	localparam logic [1:0] OCC_SEL_RST = 2'h1;
	localparam logic [1:0] OCC_MODE_A_RST = 2'h2;
	localparam logic [1:0] OCC_MODE_B_RST = 2'h0;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [1:0] {
		OCC_SRC_SYNTH_ONE = 2'h0,
		OCC_SRC_SYNTH_TWO = 2'h1,
		OCC_SRC_PRI_REF = 2'h2,
		OCC_SRC_SEC_REF = 2'h3
	} occ_src_t;

	typedef enum logic [1:0] {
		OCC_DRV_OFF = 2'h0,
		OCC_DRV_ACDIFF = 2'h1,
		OCC_DRV_HCSL = 2'h2,
		OCC_DRV_CMOS = 2'h3
	} occ_drv_t;

	// cmos pin states, shared by both pins
	localparam logic [1:0] OCC_PIN_OFF_Z = 2'h0;
	localparam logic [1:0] OCC_PIN_OFF_LOW = 2'h1;
	localparam logic [1:0] OCC_PIN_INV = 2'h2;
	localparam logic [1:0] OCC_PIN_TRUE = 2'h3;

	// tail current in mA and hcsl load in ohms
	localparam logic [4:0] OCC_TAIL_4MA = 5'h04;
	localparam logic [4:0] OCC_TAIL_6MA = 5'h06;
	localparam logic [4:0] OCC_TAIL_8MA = 5'h08;
	localparam logic [4:0] OCC_TAIL_16MA = 5'h10;
	localparam logic [7:0] OCC_LOAD_Z = 8'h00;
	localparam logic [7:0] OCC_LOAD_50 = 8'h32;
	localparam logic [7:0] OCC_LOAD_100 = 8'h64;
	localparam logic [7:0] OCC_LOAD_200 = 8'hc8;
endpackage
`default_nettype wire

// ### sim/occ_src_model.sv
// partner model: four free-running source clocks and the loads on the channel five pins
`default_nettype none
module occ_src_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// source clocks: synth one, synth two, primary, secondary
	output logic [3:0] src_clk,
	// channel five pins
	input wire logic p_out,
	input wire logic p_oe_n,
	input wire logic n_out,
	input wire logic n_oe_n,
	output logic p_line,
	output logic n_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_r [4];
	logic p_last_r;
	logic n_last_r;

	// ************************************************************
	// sources, half periods of 4 to 7 cycles, all slower than half the bus clock
	// ************************************************************
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (rst || cnt_r[i] == 3'(i + 3))
			begin
				cnt_r[i] <= 3'h0;
				src_clk[i] <= rst ? 1'b0 : ~src_clk[i];
			end
			else
				cnt_r[i] <= cnt_r[i] + 3'h1;
		end
	end

	// ************************************************************
	// released pins have no pull: show the inverse of the last driven level
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!p_oe_n)
			p_last_r <= p_out;
		if (!n_oe_n)
			n_last_r <= n_out;
	end
	assign p_line = p_oe_n ? ~p_last_r : p_out;
	assign n_line = n_oe_n ? ~n_last_r : n_out;
endmodule // occ_src_model
`default_nettype wire

// ### sim/occ_top_tb.sv
// testbench: register bank, channel five drive settings and channel four divider
`default_nettype none
module occ_top_tb
	import occ_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_DIV = {2'h0, OCC_IDX_CH4_DIV, 2'h0};
	localparam logic [11:0] A_CTL = {2'h0, OCC_IDX_CH5_CTL, 2'h0};
	localparam logic [11:0] A_SRC = {2'h0, OCC_IDX_CH4_SRC, 2'h0};
	localparam logic [11:0] A_BAD = 12'h0a0;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] src, s_d1, s_d2;
	logic ch4_out, p_out, p_oe_n, n_out, n_oe_n, p_line, n_line;
	logic [4:0] tail;
	logic [7:0] load;
	logic [4:0] tails [4] = '{OCC_TAIL_4MA, OCC_TAIL_6MA, OCC_TAIL_8MA, OCC_TAIL_16MA};
	logic [7:0] loads [4] = '{OCC_LOAD_Z, OCC_LOAD_50, OCC_LOAD_100, OCC_LOAD_200};
	logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
	int fail_count, num_checks;

	occ_top #(.ADDR_W(12)) u_occ_top (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SYNTH_ONE_CLK(src[0]), .SYNTH_TWO_CLK(src[1]), .PRI_REF_CLK(src[2]), .SEC_REF_CLK(src[3]),
		.CH4_OUT(ch4_out), .CH5_P_OUT(p_out), .CH5_P_OE_N(p_oe_n), .CH5_N_OUT(n_out), .CH5_N_OE_N(n_oe_n),
		.CH5_TAIL_MA(tail), .CH5_LOAD_OHM(load));
	occ_src_model u_occ_src_model (.clk(clk), .rst(rst), .src_clk(src), .p_out(p_out), .p_oe_n(p_oe_n),
		.n_out(n_out), .n_oe_n(n_oe_n), .p_line(p_line), .n_line(n_line));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		s_d1 <= src;
		s_d2 <= s_d1;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// called just after a rising edge; ends one idle edge later so the next setup is a fresh edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// no cycle count assumed: only the watchdog ends this wait
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		// answer stands for one access cycle only
		chk("ready pulse", {31'h0, pready}, 32'h0);
		chk("rdata idle", prdata, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, d, rd, e);
	endtask

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		chk(what, d, exp);
		chk("error flag", {31'h0, e}, {31'h0, err_exp});
	endtask

	// source rising edges between the second and third output rise; the first gap may still settle
	task automatic gap(input int s, output int n);
		int k, r;
		logic po, ps;
		po = ch4_out;
		ps = src[s];
		r = 0;
		n = 0;
		k = 0;
		while (r < 3 && k < 12000)
		begin
			@(posedge clk);
			k++;
			if (r == 2 && src[s] && !ps)
				n++;
			if (ch4_out && !po)
				r++;
			po = ch4_out;
			ps = src[s];
		end
		// a divider that never produced three rises is a mismatch too
		if (r < 3)
			fail_count++;
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		int n;
		logic [4:0] te;
		fail_count = 0;
		num_checks = 0;
		rst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("tail after reset", 32'(tail), 32'(OCC_TAIL_8MA));
		chk("oe after reset", {30'h0, p_oe_n, n_oe_n}, 32'h0);
		rd_chk("div reset", A_DIV, 32'h02, 1'b0);
		rd_chk("ctl reset", A_CTL, 32'h18, 1'b0);
		rd_chk("unmapped", A_BAD, 32'h0, 1'b1);
		for (int s = 0; s < 4; s++)
			for (int m = 0; m < 4; m++)
			begin
				wr(A_CTL, {24'h0, 2'h0, 2'(s), 2'(m), 2'(m)});
				repeat (3) @(posedge clk);
				te = (s == 2 || (s == 1 && m != 3)) ? tails[m] : (s == 1) ? OCC_TAIL_8MA : 5'h00;
				chk("tail", 32'(tail), 32'(te));
				chk("load", 32'(load), (s == 2) ? 32'(loads[m]) : 32'h0);
				chk("oe", {30'h0, p_oe_n, n_oe_n}, (s == 0 || (s == 3 && m == 0)) ? 32'h3 : 32'h0);
				if (s == 3 && m == 1)
					chk("low pins", {30'h0, p_out, n_out}, 32'h0);
			end
		rd_chk("ctl rw", A_CTL, 32'h3f, 1'b0);
		for (int s = 0; s < 4; s++)
		begin
			// cmos, positive pin true, negative pin inverted
			wr(A_CTL, {24'h0, 2'(s), 6'h3e});
			repeat (4) @(posedge clk);
			repeat (24)
			begin
				@(negedge clk);
				chk("p pin", {31'h0, p_line}, {31'h0, s_d2[s]});
				chk("n pin", {31'h0, n_line}, {31'h0, ~s_d2[s]});
			end
			@(posedge clk);
		end
		foreach (divs[i])
		begin
			wr(A_DIV, 32'(divs[i]));
			gap(0, n);
			chk("synth one gap", 32'(n), 32'(divs[i]) + 32'h1);
		end
		wr(A_SRC, 32'h1);
		wr(A_DIV, 32'h1);
		gap(1, n);
		chk("synth two gap", 32'(n), 32'h2);
		wr(A_SRC, 32'h2);
		wr(A_DIV, 32'h3);
		gap(2, n);
		chk("primary gap", 32'(n), 32'h1);
		wr(A_SRC, 32'h3);
		gap(3, n);
		chk("secondary gap", 32'(n), 32'h1);
		rd_chk("div rw", A_DIV, 32'h03, 1'b0);
		rd_chk("src rw", A_SRC, 32'h3, 1'b0);
		report_and_stop;
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule // occ_top_tb
`default_nettype wire
